// ### hdl/high_port_data_latches.sv
// Data latches, pin drivers and pin read path for ports four, five and six.
`timescale 1ns/1ns
module high_port_data_latches (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Special-function-register bus
  input  wire logic [7:0]                sfr_addr,
  input  wire logic                      sfr_wr,
  input  wire logic                      sfr_rd,
  input  wire logic [7:0]                sfr_wdata,
  output logic      [7:0]                sfr_rdata,
  // Output mode register bits from outside the block
  input  wire logic [7:0]                high_ports_output_mode,
  // External memory interface override, level signals held for a whole move
  input  wire logic                      mem_active,
  input  wire logic                      mem_muxed,
  input  wire logic [15:0]               mem_addr,
  input  wire logic                      mem_strobe_oe,
  input  wire logic [2:0]                mem_strobe_out,
  input  wire logic                      mem_data_oe,
  input  wire logic [7:0]                mem_data_out,
  // Pins
  input  wire high_port_pkg::port_bytes_t pin_in,
  output high_port_pkg::pin_drive_t      pin_four,
  output high_port_pkg::pin_drive_t      pin_five,
  output high_port_pkg::pin_drive_t      pin_six
);

  high_port_pkg::port_state_t s_r;
  high_port_pkg::port_state_t s_nxt;
  logic [7:0] mode_four;
  logic [7:0] mode_five;
  logic [7:0] mode_six;

  // ----------------------------------------------------------------
  // Register update and pin synchroniser
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = pin_in;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    if (sfr_wr) begin
      unique case (sfr_addr)
        high_port_pkg::ADDR_PORT_FOUR: s_nxt.latch.four = sfr_wdata;
        high_port_pkg::ADDR_PORT_FIVE: s_nxt.latch.five = sfr_wdata;
        high_port_pkg::ADDR_PORT_SIX:  s_nxt.latch.six  = sfr_wdata;
        default: ;
      endcase
    end
    // Third stage must agree with the second so a pin mid-transition is not returned.
    if (sfr_rd) begin
      unique case (sfr_addr)
        high_port_pkg::ADDR_PORT_FOUR:
          s_nxt.rdata = (s_r.sync2.four & s_r.sync3.four)
                      | (s_r.rdata & (s_r.sync2.four ^ s_r.sync3.four));
        high_port_pkg::ADDR_PORT_FIVE:
          s_nxt.rdata = (s_r.sync2.five & s_r.sync3.five)
                      | (s_r.rdata & (s_r.sync2.five ^ s_r.sync3.five));
        high_port_pkg::ADDR_PORT_SIX:
          s_nxt.rdata = (s_r.sync2.six & s_r.sync3.six)
                      | (s_r.rdata & (s_r.sync2.six ^ s_r.sync3.six));
        default: s_nxt.rdata = high_port_pkg::READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r.latch <= '{default: high_port_pkg::LATCH_RESET};
      s_r.sync1 <= '{default: high_port_pkg::LATCH_RESET};
      s_r.sync2 <= '{default: high_port_pkg::LATCH_RESET};
      s_r.sync3 <= '{default: high_port_pkg::LATCH_RESET};
      s_r.rdata <= high_port_pkg::READ_UNMAPPED;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sfr_rdata = s_r.rdata;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Mode bits expand nibble-wide; software wanting an input sets open-drain and a one.
  assign mode_four = {{4{high_ports_output_mode[high_port_pkg::MODE_FOUR_HI]}},
                      {4{high_ports_output_mode[high_port_pkg::MODE_FOUR_LO]}}};
  assign mode_five = {{4{high_ports_output_mode[high_port_pkg::MODE_FIVE_HI]}},
                      {4{high_ports_output_mode[high_port_pkg::MODE_FIVE_LO]}}};
  assign mode_six  = {{4{high_ports_output_mode[high_port_pkg::MODE_SIX_HI]}},
                      {4{high_ports_output_mode[high_port_pkg::MODE_SIX_LO]}}};

  // ----------------------------------------------------------------
  // External memory override
  // ----------------------------------------------------------------
  logic [7:0] six_src;
  logic [7:0] four_src;
  logic [7:0] five_src;
  logic [7:0] five_oe_gate;

  // The override is combinational so the pins follow the move within the cycle.
  // The latches keep their contents and take the pins back when the move ends.
  always_comb begin
    four_src = s_r.latch.four;
    five_src = s_r.latch.five;
    six_src  = s_r.latch.six;
    five_oe_gate = 8'hff;
    if (mem_active) begin
      six_src = mem_muxed ? mem_addr[15:8] : mem_addr[7:0];
      if (mem_strobe_oe) begin
        four_src[7:5] = mem_strobe_out;
      end
      if (mem_muxed) begin
        five_src = mem_data_out;
        five_oe_gate = {8{mem_data_oe}};
      end else begin
        five_src = mem_addr[15:8];
      end
    end
  end

  // A zero pulls low except on port five in a muxed move with mem_data_oe low; a one drives only where the nibble is push-pull.
  assign pin_four.out = four_src;
  assign pin_four.oe  = ~four_src | (four_src & mode_four);
  assign pin_five.out = five_src;
  assign pin_five.oe  = (~five_src | (five_src & mode_five)) & five_oe_gate;
  assign pin_six.out  = six_src;
  assign pin_six.oe   = ~six_src | (six_src & mode_six);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_zero_drives_low: assert property (@(posedge clk) disable iff (!rst_n)
    (!mem_active && sfr_wr && sfr_addr == high_port_pkg::ADDR_PORT_FOUR)
      |=> mem_active || ((pin_four.out == $past(sfr_wdata))
                         && ((~pin_four.out & ~pin_four.oe) == 8'h00)))
    else $error("port four write not driven");
  a_zero_low_five: assert property (@(posedge clk) disable iff (!rst_n)
    !mem_active |-> ((~pin_five.out & ~pin_five.oe) == 8'h00))
    else $error("port five zero not driven");
  a_latch_six: assert property (@(posedge clk) disable iff (!rst_n)
    !mem_active |-> (pin_six.out == s_r.latch.six))
    else $error("port six not following latch");
  a_reset_latch: assert property (@(posedge clk)
    !rst_n |=> (s_r.latch == {3{high_port_pkg::LATCH_RESET}}))
    else $error("latches not set by reset");
  a_open_drain_float: assert property (@(posedge clk) disable iff (!rst_n)
    !mem_active |-> ((pin_six.out & ~mode_six & pin_six.oe) == 8'h00))
    else $error("open-drain one driven");
  a_ovr_open_drain: assert property (@(posedge clk) disable iff (!rst_n)
    mem_active |-> ((pin_six.out & ~mode_six & pin_six.oe) == 8'h00))
    else $error("open-drain one driven during move");
  a_push_pull_high: assert property (@(posedge clk) disable iff (!rst_n)
    !mem_active |-> ((pin_five.out & mode_five & ~pin_five.oe) == 8'h00))
    else $error("push-pull one not driven");
  a_push_pull_four: assert property (@(posedge clk) disable iff (!rst_n)
    !mem_active |-> ((pin_four.out & mode_four & ~pin_four.oe) == 8'h00))
    else $error("port four push-pull one not driven");
  a_read_pins: assert property (@(posedge clk) disable iff (!rst_n)
    (sfr_rd && sfr_addr == high_port_pkg::ADDR_PORT_SIX && s_r.sync2.six == s_r.sync3.six)
      |=> sfr_rdata == $past(s_r.sync3.six))
    else $error("read does not return pins");
  a_read_five: assert property (@(posedge clk) disable iff (!rst_n)
    (sfr_rd && sfr_addr == high_port_pkg::ADDR_PORT_FIVE && s_r.sync2.five == s_r.sync3.five)
      |=> sfr_rdata == $past(s_r.sync3.five))
    else $error("port five read does not return pins");
  a_read_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
    (sfr_rd && sfr_addr != high_port_pkg::ADDR_PORT_FOUR
     && sfr_addr != high_port_pkg::ADDR_PORT_FIVE && sfr_addr != high_port_pkg::ADDR_PORT_SIX)
      |=> sfr_rdata == high_port_pkg::READ_UNMAPPED)
    else $error("unmapped read not zero");
  a_read_holds: assert property (@(posedge clk) disable iff (!rst_n)
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");
  a_muxed_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_active && mem_muxed) |-> pin_six.out == mem_addr[15:8])
    else $error("muxed address wrong");
  a_nonmux_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_active && !mem_muxed) |-> pin_six.out == mem_addr[7:0])
    else $error("non-muxed address wrong");
  a_read_release: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_active && mem_muxed && !mem_data_oe) |-> pin_five.oe == 8'h00)
    else $error("data bus driven in read");
  a_strobe_ovr: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_active && mem_strobe_oe) |-> pin_four.out[7:5] == mem_strobe_out)
    else $error("strobes not on port four");
  a_data_ovr: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_active && mem_muxed) |-> pin_five.out == mem_data_out)
    else $error("data bus not on port five");
  a_five_high_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_active && !mem_muxed) |-> pin_five.out == mem_addr[15:8])
    else $error("high address not on port five");
  a_sync_depth: assert property (@(posedge clk) disable iff (!rst_n)
    ##3 (s_r.sync3 == $past(pin_in, 3)))
    else $error("synchroniser depth wrong");
  a_nibble_mode: assert property (@(posedge clk) disable iff (!rst_n)
    (!mem_active && s_r.latch.four[7:4] == 4'hf)
      |-> pin_four.oe[7:4] == {4{high_ports_output_mode[high_port_pkg::MODE_FOUR_HI]}})
    else $error("nibble mode wrong");

  // ----------------------------------------------------------------
  // Cover properties
  // ----------------------------------------------------------------
  c_write_four: cover property (@(posedge clk) sfr_wr && sfr_addr == high_port_pkg::ADDR_PORT_FOUR);
  c_read_six: cover property (@(posedge clk) sfr_rd && sfr_addr == high_port_pkg::ADDR_PORT_SIX);
  c_mem_muxed: cover property (@(posedge clk) mem_active && mem_muxed && !mem_data_oe);
  c_mem_plain: cover property (@(posedge clk) mem_active && !mem_muxed);
  c_mem_strobe: cover property (@(posedge clk) mem_active && mem_strobe_oe);

endmodule // high_port_data_latches

// ### hdl/high_port_pkg.sv
// Package with register map, mode bit positions and carrier types for the high port latches.
package high_port_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_FOUR = 8'h84;
  localparam logic [7:0] ADDR_PORT_FIVE = 8'h85;
  localparam logic [7:0] ADDR_PORT_SIX  = 8'h86;
  localparam logic [7:0] LATCH_RESET    = 8'hff;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;

  // ----------------------------------------------------------------
  // Output mode bit positions, one bit per nibble
  // ----------------------------------------------------------------
  localparam int MODE_FOUR_LO = 0;
  localparam int MODE_FOUR_HI = 1;
  localparam int MODE_FIVE_LO = 2;
  localparam int MODE_FIVE_HI = 3;
  localparam int MODE_SIX_LO  = 4;
  localparam int MODE_SIX_HI  = 5;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] four;
    logic [7:0] five;
    logic [7:0] six;
  } port_bytes_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

  typedef struct packed {
    port_bytes_t latch;
    port_bytes_t sync1;
    port_bytes_t sync2;
    port_bytes_t sync3;
    logic [7:0]  rdata;
  } port_state_t;

endpackage

// ### verif/high_port_data_latches_test.sv
// Self-checking bench for the high port data latches.
`timescale 1ns/1ns
module high_port_data_latches_test;
  logic                       clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic [7:0]                 addr = 8'h00, wdata = 8'h00, mode = 8'h3f, rdata, v;
  logic                       wr = 1'b0, rd = 1'b0, act = 1'b0, muxed = 1'b0, d_oe = 1'b0;
  logic                       strobe_oe = 1'b0;
  logic [2:0]                 strobe_out = 3'h0;
  logic [15:0]                eaddr = 16'h0000;
  high_port_pkg::port_bytes_t pins, ext_en = '0, ext_val = '0;
  high_port_pkg::pin_drive_t  four_drv, five_drv, six_drv;
  int                         failures = 0, n_tests = 0;
  always #2 clk = ~clk;
  high_port_data_latches u_dut (.clk(clk), .rst_n(rst_n), .sfr_addr(addr), .sfr_wr(wr),
    .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata), .high_ports_output_mode(mode),
    .mem_active(act), .mem_muxed(muxed), .mem_addr(eaddr), .mem_strobe_oe(strobe_oe),
    .mem_strobe_out(strobe_out), .mem_data_oe(d_oe), .mem_data_out(8'h5a), .pin_in(pins),
    .pin_four(four_drv), .pin_five(five_drv), .pin_six(six_drv));
  pin_model u_pins (.drv_four(four_drv), .drv_five(five_drv), .drv_six(six_drv),
    .ext_en(ext_en), .ext_val(ext_val), .pins(pins));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // Pin levels need three cycles to pass the synchroniser before a read.
  task automatic rd_reg(input logic [7:0] a);
    repeat (4) @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    v = rdata;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 3; i++) begin
      rd_reg(high_port_pkg::ADDR_PORT_FOUR + 8'(i));
      chk(v, 8'hff);
    end
    rd_reg(8'h87);
    chk(v, high_port_pkg::READ_UNMAPPED);
  endtask
  task automatic t_push_pull;
    wr_reg(high_port_pkg::ADDR_PORT_FOUR, 8'h0f);
    chk(four_drv.out, 8'h0f);
    chk(four_drv.oe, 8'hff);
    rd_reg(high_port_pkg::ADDR_PORT_FOUR);
    chk(v, 8'h0f);
  endtask
  task automatic t_open_drain;
    mode = 8'h00;
    wr_reg(high_port_pkg::ADDR_PORT_FIVE, 8'h5a);
    chk(five_drv.oe, 8'ha5);
    ext_en.five = 8'hff;
    ext_val.five = 8'h3c;
    rd_reg(high_port_pkg::ADDR_PORT_FIVE);
    chk(v, 8'h18);
    wr_reg(high_port_pkg::ADDR_PORT_FIVE, 8'hff);
    rd_reg(high_port_pkg::ADDR_PORT_FIVE);
    chk(v, 8'h3c);
    ext_en = '0;
  endtask
  task automatic t_mem;
    @(negedge clk);
    mode = 8'h3f;
    act = 1'b1;
    muxed = 1'b1;
    eaddr = 16'habcd;
    strobe_oe = 1'b1;
    strobe_out = 3'h5;
    d_oe = 1'b0;
    #1 chk(six_drv.out, 8'hab);
    chk(five_drv.oe, 8'h00);
    chk(five_drv.out, 8'h5a);
    chk(four_drv.out, 8'haf);
    @(negedge clk);
    d_oe = 1'b1;
    #1 chk(five_drv.oe, 8'hff);
    @(negedge clk);
    muxed = 1'b0;
    #1 chk(six_drv.out, 8'hcd);
    chk(five_drv.out, 8'hab);
    @(negedge clk);
    act = 1'b0;
    strobe_oe = 1'b0;
    #1 chk(six_drv.out, 8'hff);
    chk(four_drv.out, 8'h0f);
  endtask
  task automatic wrap_up;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_push_pull();
    t_open_drain();
    t_mem();
    wrap_up();
  end
  // The scenarios take well under a thousand cycles.
  initial begin
    #20000;
    failures++;
    wrap_up();
  end
endmodule // high_port_data_latches_test

// ### verif/pin_model.sv
// Pin pads of ports four to six: driver, weak pull-up and an outside driver.
`timescale 1ns/1ns
module pin_model (
  // Drive from the block
  input  wire high_port_pkg::pin_drive_t  drv_four,
  input  wire high_port_pkg::pin_drive_t  drv_five,
  input  wire high_port_pkg::pin_drive_t  drv_six,
  // Outside driver on released pins
  input  wire high_port_pkg::port_bytes_t ext_en,
  input  wire high_port_pkg::port_bytes_t ext_val,
  // Levels seen at the pads
  output high_port_pkg::port_bytes_t      pins
);
  // A released pin with no outside driver rises through its weak pull-up.
  function automatic logic [7:0] lvl(high_port_pkg::pin_drive_t d, logic [7:0] e, logic [7:0] v);
    return (d.oe & d.out) | (~d.oe & e & v) | (~d.oe & ~e);
  endfunction
  assign pins.four = lvl(drv_four, ext_en.four, ext_val.four);
  assign pins.five = lvl(drv_five, ext_en.five, ext_val.five);
  assign pins.six  = lvl(drv_six, ext_en.six, ext_val.six);
endmodule // pin_model
